// >>> tbr_pkg.sv
// Package: offsets, reset values and carrier types for the test byte block
//
// Function
// - An 8-bit read/write test byte lives at offset 16h and resets to 00h.
// - Base offset takes plain reads and whole-byte writes, aliases set/clear.
// - No access at any of the three offsets affects transceiver behaviour.
// - Offset 17h has no storage of its own and reads the test byte value.
// - A write to 17h sets each bit written as one, others stay unchanged.
// - Offset 18h has no storage of its own and reads the test byte value.
// - A write to 18h clears each bit written as one, others stay unchanged.
package tbr_pkg;

  localparam int          TBR_ADDR_W     = 6;
  localparam int          TBR_DATA_W     = 8;
  localparam logic [5:0]  TBR_OFS_BASE   = 6'h16;
  localparam logic [5:0]  TBR_OFS_SET    = 6'h17;
  localparam logic [5:0]  TBR_OFS_CLR    = 6'h18;
  localparam logic [7:0]  TBR_RESET_VAL  = 8'h00;
  localparam logic [7:0]  TBR_UNMAPPED   = 8'h00;

  // Register access request from the link interface decoder
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [5:0] addr;
    logic [7:0] wdata;
  } tbr_req_t;

  // Read answer back to the link interface
  typedef struct packed {
    logic       rd_valid;
    logic       hit;
    logic [7:0] rdata;
  } tbr_rsp_t;

  typedef enum logic [1:0] {
    TBR_OP_NONE,
    TBR_OP_WRITE,
    TBR_OP_SET,
    TBR_OP_CLEAR
  } tbr_op_t;

endpackage

// >>> tbr_decode.sv
// Address decode of one register access into a test byte operation
`timescale 1ns/10ps
module tbr_decode
  import tbr_pkg::*;
(
  input  wire tbr_req_t req,
  output tbr_op_t       op,
  output logic          hit
);

  // Three offsets map to one storage element
  always_comb begin
    op  = TBR_OP_NONE;
    hit = 1'h1;
    case (req.addr)
      TBR_OFS_BASE: begin
        if (req.wr_en) op = TBR_OP_WRITE;
      end
      TBR_OFS_SET: begin
        if (req.wr_en) op = TBR_OP_SET;
      end
      TBR_OFS_CLR: begin
        if (req.wr_en) op = TBR_OP_CLEAR;
      end
      default: begin
        hit = 1'h0;
      end
    endcase
  end

endmodule

// >>> tbr_test_byte.sv
// Test byte register with set and clear aliases
`timescale 1ns/10ps
module tbr_test_byte
  import tbr_pkg::*;
(
  input  wire logic     core_clk,
  input  wire logic     rstn,
  input  wire tbr_req_t req,
  output tbr_rsp_t      rsp
);

  //////////////////////////////////////////////////////////////////////////
  // Local signals

  // Request fields used here; same clock as the link side
  logic             req_wr;
  logic             req_rd;
  logic [7:0]       req_wdata;

  // Decoded operation and address match
  tbr_op_t          op;
  logic             hit;

  // One-hot view of the decoded operation
  logic             op_write;
  logic             op_set;
  logic             op_clear;

  // The test byte itself, the only storage behind the three offsets
  logic [7:0]       byte_q;
  logic [7:0]       byte_d;

  // Read answer registers and the read data next value
  logic             rd_valid_q;
  logic             hit_q;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;

  //////////////////////////////////////////////////////////////////////////
  // Request views

  // No synchroniser: requests come from logic on core_clk
  assign req_wr    = req.wr_en;
  assign req_rd    = req.rd_en;
  assign req_wdata = req.wdata;

  //////////////////////////////////////////////////////////////////////////
  // Decode

  // Three offsets, one storage element
  tbr_decode u_decode (
    .req (req),
    .op  (op),
    .hit (hit)
  );

  // Operation flags; at most one is high in any cycle
  always_comb begin
    op_write = 1'h0;
    op_set   = 1'h0;
    op_clear = 1'h0;
    case (op)
      TBR_OP_WRITE: begin
        op_write = 1'h1;
      end
      TBR_OP_SET: begin
        op_set = 1'h1;
      end
      TBR_OP_CLEAR: begin
        op_clear = 1'h1;
      end
      default: begin
        op_write = 1'h0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Next value, bit by bit; aliases act on the stored byte itself

  // Zero bits of a set or clear leave their stored bit alone
  for (genvar i = 0; i < TBR_DATA_W; i++) begin : g_bit
    always_comb begin
      if (op_write) begin
        byte_d[i] = req_wdata[i];
      end else if (op_set && req_wdata[i]) begin
        byte_d[i] = 1'h1;
      end else if (op_clear && req_wdata[i]) begin
        byte_d[i] = 1'h0;
      end else begin
        byte_d[i] = byte_q[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Storage

  // Not wired to any transceiver function, so no side effects
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      byte_q <= TBR_RESET_VAL;
    end else begin
      byte_q <= byte_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read answer

  // Old byte wins over a same-cycle write; unmapped reads give zero
  always_comb begin
    rdata_d = TBR_UNMAPPED;
    if (req_rd && hit) begin
      rdata_d = byte_q;
    end
  end

  // Read strobe, answered one cycle later
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_valid_q <= 1'h0;
    end else begin
      rd_valid_q <= req_rd;
    end
  end

  // Address match flag, tracks every cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hit_q <= 1'h0;
    end else begin
      hit_q <= hit;
    end
  end

  // Read data register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= TBR_UNMAPPED;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // Answer carrier, straight from flip-flops
  assign rsp = '{rd_valid: rd_valid_q, hit: hit_q, rdata: rdata_q};

endmodule

// >>> tbr_assertions.sv
// Checker for the test byte block
`timescale 1ns/10ps
module tbr_assertions import tbr_pkg::*; (
  input wire logic     core_clk,
  input wire logic     rstn,
  input wire tbr_req_t req,
  input wire tbr_rsp_t rsp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Short views; m marks the three mapped offsets
  wire       r = req.rd_en, w = req.wr_en;
  wire [5:0] a = req.addr;
  wire [7:0] d = req.wdata, q = rsp.rdata;
  wire       m = a inside {[TBR_OFS_BASE:TBR_OFS_CLR]}, s = r && !w && m;
  a_read_lag: assert property (r |=> rsp.rd_valid)
    else $error("lag");
  a_hit_flag: assert property (r |=> rsp.hit == $past(m))
    else $error("hit");
  a_idle_quiet: assert property (!r |=> !rsp.rd_valid && !q)
    else $error("idle");
  a_unmapped_zero: assert property (r && !m |=> !q)
    else $error("unmap");
  a_alias_same: assert property (
    s ##1 r && m |=> q == $past(q)) else $error("alias");
  a_write_base: assert property (
    w && a == TBR_OFS_BASE ##1 s |=> q == $past(d, 2)) else $error("wr");
  a_set_bits: assert property (
    w && a == TBR_OFS_SET ##1 s |=> &(q | ~$past(d, 2)))
    else $error("set");
  a_clear_bits: assert property (
    w && a == TBR_OFS_CLR ##1 s |=> !(q & $past(d, 2)))
    else $error("clr");
endmodule
bind tbr_test_byte tbr_assertions u_chk (.core_clk(core_clk), .rstn(rstn),
  .req(req), .rsp(rsp));

// >>> tbr_link_model.sv
// Link controller model issuing single-byte register accesses
`timescale 1ns/10ps
module tbr_link_model import tbr_pkg::*; (
  input  wire logic core_clk,
  output tbr_req_t  req
);
  initial req = {2'h0, 6'h3F, 8'hFF};
  // Held across the taking edge; caller enters just after an edge
  task acc(logic [1:0] o, logic [5:0] a, logic [7:0] d);
    req = {o, a, d};
    @(posedge core_clk);
    #1;
  endtask
endmodule

// >>> test_byte_with_set_clear_aliases_tb_top.sv
// Testbench for the test byte block
`timescale 1ns/10ps
module test_byte_with_set_clear_aliases_tb_top;
  import tbr_pkg::*;
  logic     core_clk = 1'h0, rstn = 1'h0;
  tbr_req_t req;
  tbr_rsp_t rsp;
  int       fail_count = 0, checks_done = 0;
  tbr_link_model lm (.core_clk(core_clk), .req(req));
  tbr_test_byte dut (.core_clk(core_clk), .rstn(rstn), .req(req), .rsp(rsp));
  initial forever #25 core_clk = ~core_clk;
  task chk(logic [9:0] s, logic [9:0] e);
    checks_done++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Answer is settled one step after the taking edge
  task t(logic [1:0] o, logic [5:0] a, logic [7:0] d, logic [9:0] e);
    lm.acc(o, a, d);
    if (o[0]) chk(rsp, e);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rstn = 1'h1;
    t(2'h1, 6'h16, 8'h00, 10'h300);
    t(2'h2, 6'h16, 8'hA5, 10'h000);
    t(2'h1, 6'h16, 8'h00, 10'h3A5);
    t(2'h2, 6'h17, 8'h0F, 10'h000);
    t(2'h1, 6'h17, 8'h00, 10'h3AF);
    t(2'h2, 6'h18, 8'h81, 10'h000);
    t(2'h1, 6'h18, 8'h00, 10'h32E);
    t(2'h1, 6'h16, 8'h00, 10'h32E);
    t(2'h1, 6'h20, 8'h00, 10'h200);
    t(2'h2, 6'h19, 8'hFF, 10'h000);
    t(2'h1, 6'h15, 8'h00, 10'h200);
    t(2'h1, 6'h16, 8'h00, 10'h32E);
    t(2'h3, 6'h16, 8'h3C, 10'h32E);
    t(2'h1, 6'h16, 8'h00, 10'h33C);
    rstn = 1'h0;
    @(posedge core_clk);
    #1 rstn = 1'h1;
    t(2'h1, 6'h18, 8'h00, 10'h300);
    give_verdict;
  end
endmodule
